// ===== hw/scpm_pkg.sv
package scpm_pkg;
  // register byte addresses (one aligned word each)
  localparam logic [3:0] ADDR_CLK_MODE = 4'h0;   // clock_mode_control_reg
  localparam logic [3:0] ADDR_FAST_OSC = 4'h4;   // fast oscillator control
  localparam logic [3:0] ADDR_STATUS = 4'h8;     // power status / mode
  localparam logic [3:0] ADDR_CMD = 4'hc;        // halt / wake / watchdog commands
  // clock mode register fields
  localparam int SEL_LSB = 5;
  localparam int SEL_MSB = 7;
  localparam int FAST_KEEP_BIT = 1;
  localparam int SLOW_KEEP_BIT = 0;
  // fast oscillator register fields
  localparam int FOSC_EN_BIT = 0;
  localparam int FOSC_STABLE_BIT = 1;
  // status register fields
  localparam int PDF_BIT = 4;
  localparam int WDOG_FLAG_BIT = 5;
  localparam int MODE_LSB = 8;
  localparam int MODE_MSB = 10;
  // command register fields (write one)
  localparam int CMD_HALT_BIT = 0;
  localparam int CMD_WAKE_BIT = 1;
  localparam int CMD_WDOG_CLR_BIT = 2;
  // reset values and selection codes
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic FOSC_EN_RESET = 1'b1;
  localparam logic [2:0] SEL_SUB = 3'h7;
  localparam logic [2:0] SEL_DIV_MAX = 3'h6;
  // divider and stabilisation
  localparam int DIV_WIDTH = 6;
  localparam logic [DIV_WIDTH-1:0] DIV_ONE = 6'h01;
  localparam int STAB_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB_WIDTH = 6;

  // operating modes, gray coded along normal-slow-halt paths
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_SLOW = 3'h1,
    MODE_LOW_IDLE = 3'h3,
    MODE_BOTH_IDLE = 3'h2,
    MODE_HIGH_IDLE = 3'h6,
    MODE_SLEEP = 3'h4
  } scpm_mode_t;

  // selection picks the divided fast clock
  function automatic logic sel_is_fast(input logic [2:0] sel);
    sel_is_fast = (sel <= SEL_DIV_MAX);
  endfunction
endpackage

// ===== hw/scpm_clk_div.sv
`timescale 1ns/1ns
// divides the fast clock tick stream by a power of two (1..64)
module scpm_clk_div (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic fastTick,
  input wire logic [2:0] sysClkSelect,
  output logic divTick
);
  logic [scpm_pkg::DIV_WIDTH-1:0] cnt_ff, nxt_cnt;
  logic divTick_ff, nxt_divTick;
  logic [scpm_pkg::DIV_WIDTH-1:0] lastCnt;

  ////////////////////////////////////////////////////////////////////
  // terminal count is ratio minus one
  always_comb begin
    lastCnt = (scpm_pkg::DIV_ONE << sysClkSelect) - scpm_pkg::DIV_ONE;
    nxt_cnt = cnt_ff;
    nxt_divTick = 1'b0;
    if (fastTick) begin
      if (cnt_ff >= lastCnt) begin
        nxt_cnt = '0;
        nxt_divTick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + scpm_pkg::DIV_ONE;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_ff <= '0;
      divTick_ff <= 1'b0;
    end else if (clkEn) begin
      cnt_ff <= nxt_cnt;
      divTick_ff <= nxt_divTick;
    end
  end

  assign divTick = divTick_ff;
endmodule

// ===== hw/scpm_osc_stab.sv
`timescale 1ns/1ns
// stable flag: clears while the oscillator is stopped, sets after the stabilisation count
module scpm_osc_stab (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic oscRun,
  output logic stable
);
  localparam logic [scpm_pkg::STAB_WIDTH-1:0] STAB_LAST =
    scpm_pkg::STAB_WIDTH'(scpm_pkg::STAB_CYCLES - 1);
  logic [scpm_pkg::STAB_WIDTH-1:0] cnt_ff, nxt_cnt;
  logic stable_ff, nxt_stable;

  ////////////////////////////////////////////////////////////////////
  // count while running, drop to zero when stopped
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_stable = stable_ff;
    if (!oscRun) begin
      nxt_cnt = '0;
      nxt_stable = 1'b0;
    end else if (!stable_ff) begin
      if (cnt_ff >= STAB_LAST) begin
        nxt_stable = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_ff <= '0;
      stable_ff <= 1'b0;
    end else if (clkEn) begin
      cnt_ff <= nxt_cnt;
      stable_ff <= nxt_stable;
    end
  end

  assign stable = stable_ff;
endmodule

// ===== hw/scpm_clock_ctrl.sv
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// Summary of operation
// - system clock from fast or sub clock
// - fast clock comes from fast RC oscillator
// - sub clock comes from slow RC oscillator
// - normal mode divides fast clock 1..64
// - after switch, fast oscillator follows enable bit
// - six modes: normal, slow, sleep, three idles
// - slow mode runs CPU from sub clock
// - slow mode gates fast clock by enable
// - halt, both keeps low: sleep, sub stops
// - sleep keeps slow oscillator only with watchdog
// - halt, slow keep only: low-speed idle
// - halt, both keeps: both-oscillator idle
// - halt, fast keep only: high-speed idle
// - selection encoding, reset value zero
// - stable flag clears, then sets when stable
// - halt sets power-down, clears watchdog flag
module scpm_clock_ctrl (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  // oscillator tick streams, one mclk pulse per oscillator edge
  input wire logic fastRcTick,
  input wire logic slowRcTick,
  // watchdog enable and time-out event from the watchdog
  input wire logic watchdogEnable,
  input wire logic wdogTimeout,
  // wake-up event ending a halt
  input wire logic wakeUp,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // clock outputs as tick enables, plus oscillator run flags
  output logic systemClockOut,
  output logic cpuClockEn,
  output logic fastClockOut,
  output logic subClockOut,
  output logic slowOscClock,
  output logic fastOscRunOut,
  output logic slowOscRunOut
);
  scpm_pkg::scpm_mode_t mode_ff, nxt_mode;
  logic [2:0] sel_ff, nxt_sel;
  logic fastKeep_ff, nxt_fastKeep;
  logic slowKeep_ff, nxt_slowKeep;
  logic fastEn_ff, nxt_fastEn;
  logic pdf_ff, nxt_pdf;
  logic wdogFlag_ff, nxt_wdogFlag;
  logic [31:0] rdData_ff, nxt_rdData;
  logic ack_ff, nxt_ack;
  logic sysClk_ff, nxt_sysClk;
  logic cpuEn_ff, nxt_cpuEn;
  logic fastOut_ff, nxt_fastOut;
  logic subOut_ff, nxt_subOut;
  logic slowOsc_ff, nxt_slowOsc;
  logic fastRun_ff, nxt_fastRun;
  logic slowRun_ff, nxt_slowRun;
  logic divTick, fastStable;
  logic wbReq, wbWr, haltCmd, wakeCmd, wdogClrCmd;

  // cpu-on mode that a selection implies
  function automatic scpm_pkg::scpm_mode_t run_mode(input logic [2:0] sel);
    run_mode = scpm_pkg::sel_is_fast(sel) ? scpm_pkg::MODE_NORMAL : scpm_pkg::MODE_SLOW;
  endfunction

  // cpu-off mode chosen by the fast and slow halt-keep bits
  function automatic scpm_pkg::scpm_mode_t halt_target(
    input logic fastKeep,
    input logic slowKeep
  );
    case ({fastKeep, slowKeep})
      2'h0: halt_target = scpm_pkg::MODE_SLEEP;
      2'h1: halt_target = scpm_pkg::MODE_LOW_IDLE;
      2'h3: halt_target = scpm_pkg::MODE_BOTH_IDLE;
      default: halt_target = scpm_pkg::MODE_HIGH_IDLE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // fast clock divider and stabilisation tracker
  scpm_clk_div uDiv (
    .mclk(mclk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .fastTick(fastRcTick & fastRun_ff),
    .sysClkSelect(sel_ff),
    .divTick(divTick)
  );

  scpm_osc_stab uStab (
    .mclk(mclk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .oscRun(fastRun_ff),
    .stable(fastStable)
  );

  ////////////////////////////////////////////////////////////////////
  // bus decode; ack one cycle after request, dropped the next
  always_comb begin
    wbReq = wb_cyc_i & wb_stb_i & ~ack_ff;
    wbWr = wbReq & wb_we_i & wb_sel_i[0];
    haltCmd = wbWr && (wb_adr_i == scpm_pkg::ADDR_CMD) && wb_dat_i[scpm_pkg::CMD_HALT_BIT];
    wakeCmd = wbWr && (wb_adr_i == scpm_pkg::ADDR_CMD) && wb_dat_i[scpm_pkg::CMD_WAKE_BIT];
    wdogClrCmd = wbWr && (wb_adr_i == scpm_pkg::ADDR_CMD)
      && wb_dat_i[scpm_pkg::CMD_WDOG_CLR_BIT];
  end

  ////////////////////////////////////////////////////////////////////
  // read mux; data only in the answer cycle
  always_comb begin
    nxt_ack = wbReq;
    nxt_rdData = '0;
    if (wbReq && !wb_we_i) begin
      case (wb_adr_i)
        scpm_pkg::ADDR_CLK_MODE: begin
          nxt_rdData[scpm_pkg::SEL_MSB:scpm_pkg::SEL_LSB] = sel_ff;
          nxt_rdData[scpm_pkg::FAST_KEEP_BIT] = fastKeep_ff;
          nxt_rdData[scpm_pkg::SLOW_KEEP_BIT] = slowKeep_ff;
        end
        scpm_pkg::ADDR_FAST_OSC: begin
          nxt_rdData[scpm_pkg::FOSC_EN_BIT] = fastEn_ff;
          nxt_rdData[scpm_pkg::FOSC_STABLE_BIT] = fastStable;
        end
        scpm_pkg::ADDR_STATUS: begin
          nxt_rdData[scpm_pkg::PDF_BIT] = pdf_ff;
          nxt_rdData[scpm_pkg::WDOG_FLAG_BIT] = wdogFlag_ff;
          nxt_rdData[scpm_pkg::MODE_MSB:scpm_pkg::MODE_LSB] = mode_ff;
        end
        // unmapped addresses answer with zero
        default: nxt_rdData = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control registers and mode sequencing
  always_comb begin
    nxt_sel = sel_ff;
    nxt_fastKeep = fastKeep_ff;
    nxt_slowKeep = slowKeep_ff;
    nxt_fastEn = fastEn_ff;
    nxt_pdf = pdf_ff;
    nxt_wdogFlag = wdogFlag_ff;
    nxt_mode = mode_ff;
    if (wbWr && wb_adr_i == scpm_pkg::ADDR_CLK_MODE) begin
      nxt_sel = wb_dat_i[scpm_pkg::SEL_MSB:scpm_pkg::SEL_LSB];
      nxt_fastKeep = wb_dat_i[scpm_pkg::FAST_KEEP_BIT];
      nxt_slowKeep = wb_dat_i[scpm_pkg::SLOW_KEEP_BIT];
    end
    if (wbWr && wb_adr_i == scpm_pkg::ADDR_FAST_OSC) begin
      nxt_fastEn = wb_dat_i[scpm_pkg::FOSC_EN_BIT];
    end
    // watchdog clear: both flags to zero; a time-out in the same cycle wins
    if (wdogClrCmd) begin
      nxt_pdf = 1'b0;
      nxt_wdogFlag = 1'b0;
    end
    case (mode_ff)
      scpm_pkg::MODE_NORMAL,
      scpm_pkg::MODE_SLOW: begin
        // mode follows selection while CPU runs
        nxt_mode = run_mode(nxt_sel);
        if (haltCmd) begin
          // halt only from a cpu-on mode; a second one while off is ignored
          nxt_pdf = 1'b1;
          nxt_wdogFlag = 1'b0;
          nxt_mode = halt_target(fastKeep_ff, slowKeep_ff);
        end
      end
      scpm_pkg::MODE_LOW_IDLE,
      scpm_pkg::MODE_BOTH_IDLE,
      scpm_pkg::MODE_HIGH_IDLE,
      scpm_pkg::MODE_SLEEP: begin
        if (wakeUp || wakeCmd) begin
          nxt_mode = run_mode(sel_ff);
        end
      end
      default: nxt_mode = scpm_pkg::MODE_NORMAL;
    endcase
    // expiry set comes last so it wins over halt and clear
    if (wdogTimeout) begin
      nxt_wdogFlag = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // oscillator gating and clock outputs per mode
  always_comb begin
    nxt_fastRun = 1'b1;
    nxt_slowRun = 1'b1;
    nxt_cpuEn = 1'b0;
    case (mode_ff)
      scpm_pkg::MODE_NORMAL: begin
        nxt_fastRun = 1'b1;
        nxt_cpuEn = 1'b1;
      end
      scpm_pkg::MODE_SLOW: begin
        nxt_fastRun = fastEn_ff;
        nxt_cpuEn = 1'b1;
      end
      scpm_pkg::MODE_LOW_IDLE: nxt_fastRun = 1'b0;
      scpm_pkg::MODE_BOTH_IDLE: nxt_fastRun = 1'b1;
      scpm_pkg::MODE_HIGH_IDLE: begin
        nxt_fastRun = 1'b1;
        nxt_slowRun = 1'b1; // slow oscillator stays on, only the sub clock stops
      end
      scpm_pkg::MODE_SLEEP: begin
        nxt_fastRun = 1'b0;
        nxt_slowRun = watchdogEnable;
      end
      default: nxt_fastRun = 1'b1;
    endcase
    // selected source: divided fast clock or sub clock
    nxt_sysClk = scpm_pkg::sel_is_fast(sel_ff) ? (divTick & fastRun_ff)
      : (slowRcTick & slowRun_ff);
    case (mode_ff)
      scpm_pkg::MODE_SLEEP: nxt_sysClk = 1'b0;
      scpm_pkg::MODE_LOW_IDLE: begin
        if (scpm_pkg::sel_is_fast(sel_ff)) nxt_sysClk = 1'b0;
      end
      scpm_pkg::MODE_HIGH_IDLE: begin
        if (!scpm_pkg::sel_is_fast(sel_ff)) nxt_sysClk = 1'b0;
      end
      default: nxt_sysClk = nxt_sysClk;
    endcase
    nxt_cpuEn = nxt_cpuEn & nxt_sysClk;
    // gated by the next run enables so a tick never outlives its oscillator
    nxt_fastOut = fastRcTick & nxt_fastRun;
    nxt_slowOsc = slowRcTick & nxt_slowRun;
    // sub clock to peripherals is off in sleep and in high-speed idle
    nxt_subOut = slowRcTick & nxt_slowRun & (mode_ff != scpm_pkg::MODE_SLEEP)
      & (mode_ff != scpm_pkg::MODE_HIGH_IDLE);
  end

  ////////////////////////////////////////////////////////////////////
  // bus answer registers; frozen with the rest while clkEn is low
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdData_ff <= '0;
      ack_ff <= 1'b0;
    end else if (clkEn) begin
      rdData_ff <= nxt_rdData;
      ack_ff <= nxt_ack;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control and mode registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mode_ff <= scpm_pkg::MODE_NORMAL;
      sel_ff <= scpm_pkg::SEL_RESET;
      fastKeep_ff <= 1'b0;
      slowKeep_ff <= 1'b0;
      fastEn_ff <= scpm_pkg::FOSC_EN_RESET;
      pdf_ff <= 1'b0;
      wdogFlag_ff <= 1'b0;
    end else if (clkEn) begin
      mode_ff <= nxt_mode;
      sel_ff <= nxt_sel;
      fastKeep_ff <= nxt_fastKeep;
      slowKeep_ff <= nxt_slowKeep;
      fastEn_ff <= nxt_fastEn;
      pdf_ff <= nxt_pdf;
      wdogFlag_ff <= nxt_wdogFlag;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock output and run registers; both oscillators run out of reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sysClk_ff <= 1'b0;
      cpuEn_ff <= 1'b0;
      fastOut_ff <= 1'b0;
      subOut_ff <= 1'b0;
      slowOsc_ff <= 1'b0;
      fastRun_ff <= 1'b1;
      slowRun_ff <= 1'b1;
    end else if (clkEn) begin
      sysClk_ff <= nxt_sysClk;
      cpuEn_ff <= nxt_cpuEn;
      fastOut_ff <= nxt_fastOut;
      subOut_ff <= nxt_subOut;
      slowOsc_ff <= nxt_slowOsc;
      fastRun_ff <= nxt_fastRun;
      slowRun_ff <= nxt_slowRun;
    end
  end

  assign wb_dat_o = rdData_ff;
  assign wb_ack_o = ack_ff;
  assign systemClockOut = sysClk_ff;
  assign cpuClockEn = cpuEn_ff;
  assign fastClockOut = fastOut_ff;
  assign subClockOut = subOut_ff;
  assign slowOscClock = slowOsc_ff;
  assign fastOscRunOut = fastRun_ff;
  assign slowOscRunOut = slowRun_ff;
endmodule

// ===== sim/scpm_ctrl_props.sv
`timescale 1ns/1ns
// port relations of the clock controller
module scpm_ctrl_props (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic slowRcTick,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic systemClockOut,
  input wire logic cpuClockEn,
  input wire logic fastClockOut,
  input wire logic subClockOut,
  input wire logic slowOscClock,
  input wire logic fastOscRunOut,
  input wire logic slowOscRunOut
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // bus answer timing
  property p_ack_pulse;
    wb_ack_o && clkEn |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside answer");
  ////////////////////////////////////////
  // clock gating relations
  property p_cpu_sys;
    cpuClockEn |-> systemClockOut;
  endproperty
  a_cpu_sys: assert property (p_cpu_sys) else $error("cpu tick without system tick");
  property p_fast_gate;
    !fastOscRunOut |-> !fastClockOut;
  endproperty
  a_fast_gate: assert property (p_fast_gate) else $error("fast tick while stopped");
  property p_slow_gate;
    !slowOscRunOut |-> !slowOscClock && !subClockOut;
  endproperty
  a_slow_gate: assert property (p_slow_gate) else $error("slow tick while stopped");
  property p_sub_src;
    subClockOut && $past(clkEn) |-> $past(slowRcTick) || $past(slowRcTick, 2);
  endproperty
  a_sub_src: assert property (p_sub_src) else $error("sub tick without slow tick");
  property p_run_reset;
    $rose(reset_n) |-> fastOscRunOut && slowOscRunOut;
  endproperty
  a_run_reset: assert property (p_run_reset) else $error("oscillators off after reset");
  c_ack: cover property (wb_ack_o);
  c_cpu: cover property (cpuClockEn);
  c_fast_off: cover property ($fell(fastOscRunOut));
endmodule
bind scpm_clock_ctrl scpm_ctrl_props chk_u (
  .mclk, .reset_n, .clkEn, .slowRcTick, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .systemClockOut, .cpuClockEn, .fastClockOut, .subClockOut, .slowOscClock,
  .fastOscRunOut, .slowOscRunOut
);

// ===== sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic mclk = 1'h0, reset_n = 1'h0, clkEn = 1'h1, fastRcTick = 1'h0, slowRcTick = 1'h0;
  logic watchdogEnable = 1'h0, wdogTimeout = 1'h0, wakeUp = 1'h0, fastFull = 1'h0;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic systemClockOut, cpuClockEn, fastClockOut, subClockOut, slowOscClock;
  logic fastOscRunOut, slowOscRunOut;
  logic [2:0] sel, m;
  logic [1:0] k;
  int nErrors = 0, testsRun = 0, nSys = 0, nCpu = 0, nSub = 0, s0, s1, s2, e;
  always #20 mclk = ~mclk;
  scpm_clock_ctrl dut_u (.mclk, .reset_n, .clkEn, .fastRcTick, .slowRcTick, .watchdogEnable,
    .wdogTimeout, .wakeUp, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .systemClockOut, .cpuClockEn, .fastClockOut, .subClockOut,
    .slowOscClock, .fastOscRunOut, .slowOscRunOut);
  ////////////////////////////////////////
  // random oscillator ticks and tick counters
  always @(posedge mclk) begin
    fastRcTick <= fastFull | ($urandom % 2 == 1);
    slowRcTick <= ($urandom % 8 == 0);
    nSys <= nSys + systemClockOut;
    nCpu <= nCpu + cpuClockEn;
    nSub <= nSub + subClockOut;
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge mclk); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  function automatic logic [2:0] halt_mode(input logic [1:0] kk);
    case (kk)
      2'h0: return scpm_pkg::MODE_SLEEP;
      2'h1: return scpm_pkg::MODE_LOW_IDLE;
      2'h2: return scpm_pkg::MODE_HIGH_IDLE;
      default: return scpm_pkg::MODE_BOTH_IDLE;
    endcase
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////
  // hang guard
  initial begin
    #400000;
    nErrors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h64ca21fe));
    repeat (12) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (30) @(posedge mclk);
    wb(1'h0, scpm_pkg::ADDR_CLK_MODE, 32'h0);
    check(rd, 32'h0);
    wb(1'h0, scpm_pkg::ADDR_FAST_OSC, 32'h0);
    check(rd, 32'h3);
    wb(1'h1, 4'h2, 32'hff);
    wb(1'h0, 4'h2, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
    // divide ratios in normal mode with a full-rate fast clock
    fastFull <= 1'h1;
    for (int r = 0; r < 7; r++) begin
      wb(1'h1, scpm_pkg::ADDR_CLK_MODE, {24'h0, 3'(r), 5'h0});
      repeat (4) @(posedge mclk);
      s1 = nCpu;
      repeat (128) @(posedge mclk);
      e = 128 >> r;
      check(32'(nCpu - s1 >= e - 1 && nCpu - s1 <= e + 1), 32'h1);
    end
    $display("test divide done");
    // every halt-keep combination, fast and sub selection
    for (int i = 0; i < 8; i++) begin
      k = i[1:0];
      sel = i[2] ? scpm_pkg::SEL_SUB : 3'($urandom % 7);
      m = i[2] ? scpm_pkg::MODE_SLOW : scpm_pkg::MODE_NORMAL;
      watchdogEnable <= 1'($urandom % 2);
      wb(1'h1, scpm_pkg::ADDR_CLK_MODE, {24'h0, sel, 3'h0, k});
      @(posedge mclk);
      wdogTimeout <= 1'h1;
      @(posedge mclk);
      wdogTimeout <= 1'h0;
      wb(1'h0, scpm_pkg::ADDR_STATUS, 32'h0);
      check(rd & 32'h720, {21'h0, m, 2'h0, 1'h1, 5'h0});
      wb(1'h1, scpm_pkg::ADDR_CMD, 32'h1);
      wb(1'h0, scpm_pkg::ADDR_STATUS, 32'h0);
      check(rd, {21'h0, halt_mode(k), 2'h0, 1'h0, 1'h1, 4'h0});
      s0 = nSys;
      s1 = nCpu;
      s2 = nSub;
      repeat (100) @(posedge mclk);
      check(32'(nCpu != s1), 32'h0);
      e = (k == 2'h3) || (k == 2'h1 && i[2]) || (k == 2'h2 && !i[2]);
      check(32'(nSys != s0), 32'(e));
      check(32'(nSub != s2), 32'(k[0]));
      check(32'(fastOscRunOut), 32'(k[1]));
      check(32'(slowOscRunOut), 32'(k != 2'h0 || watchdogEnable));
      if (i % 2 == 1) begin
        @(posedge mclk);
        wakeUp <= 1'h1;
        @(posedge mclk);
        wakeUp <= 1'h0;
      end else begin
        wb(1'h1, scpm_pkg::ADDR_CMD, 32'h2);
      end
      wb(1'h0, scpm_pkg::ADDR_STATUS, 32'h0);
      check(rd & 32'h700, {21'h0, m, 8'h0});
    end
    $display("test halt done");
    // fast oscillator off in slow mode, then restart
    fastFull <= 1'h0;
    wb(1'h1, scpm_pkg::ADDR_FAST_OSC, 32'h0);
    repeat (3) @(posedge mclk);
    check(32'(fastOscRunOut), 32'h0);
    wb(1'h0, scpm_pkg::ADDR_FAST_OSC, 32'h0);
    check(rd, 32'h0);
    wb(1'h1, scpm_pkg::ADDR_FAST_OSC, 32'h1);
    wb(1'h0, scpm_pkg::ADDR_FAST_OSC, 32'h0);
    check(rd, 32'h1);
    // clock enable low freezes the stabilisation count
    clkEn <= 1'h0;
    repeat (30) @(posedge mclk);
    clkEn <= 1'h1;
    wb(1'h0, scpm_pkg::ADDR_FAST_OSC, 32'h0);
    check(rd, 32'h1);
    repeat (30) @(posedge mclk);
    wb(1'h0, scpm_pkg::ADDR_FAST_OSC, 32'h0);
    check(rd, 32'h3);
    check(32'(fastOscRunOut), 32'h1);
    wb(1'h1, scpm_pkg::ADDR_CLK_MODE, 32'h0);
    wb(1'h1, scpm_pkg::ADDR_CMD, 32'h4);
    wb(1'h0, scpm_pkg::ADDR_STATUS, 32'h0);
    check(rd, 32'h0);
    $display("test fast restart done");
    wrap_up();
  end
endmodule
